//--- core/mac_addr_filter.sv
// Destination address checker: perfect, hash, multicast and promiscuous
`timescale 1ns/1ps
module mac_addr_filter (
    input wire logic clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic [47:0] destAddr,
    input wire logic [47:0] stationAddr,
    input wire logic [63:0] hashTable,
    input wire logic promiscuous,
    input wire logic passAllMulticast,
    input wire logic inverseFilter,
    input wire logic hashOnlyFilter,
    input wire logic hashPerfectSelect,
    output logic filterPass
);
    import mac_mode_pkg::*;

    function automatic logic [5:0] hashIndex(input logic [47:0] addr);
        logic [31:0] crc;
        logic fb;
        crc = CRC_INIT;
        fb = 1'b0;
        for (int i = 0; i < 48; i++) begin
            fb = crc[31] ^ addr[i];
            crc = {crc[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h0000_0000);
        end
        return crc[31:26];
    endfunction

    logic multicast;
    logic perfectHit;
    logic hashHit;
    logic decision;

    assign multicast = destAddr[0];
    assign perfectHit = (destAddr == stationAddr);
    assign hashHit = hashTable[hashIndex(destAddr)];

    always_comb begin
        if (promiscuous) begin
            decision = 1'b1;
        end else if (multicast && passAllMulticast) begin
            decision = 1'b1;
        end else if (!hashPerfectSelect) begin
            decision = perfectHit ^ inverseFilter;
        end else if (multicast || hashOnlyFilter) begin
            decision = hashHit;
        end else begin
            decision = perfectHit;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            filterPass <= 1'b0;
        end else if (start) begin
            filterPass <= decision;
        end
    end

    property p_mcast_pass;
        @(posedge clk) disable iff (!resetn)
        (start && passAllMulticast && destAddr[0]) |=> filterPass;
    endproperty
    a_mcast_pass: assert property (p_mcast_pass)
        else $error("multicast frame not passed");

    property p_inverse;
        @(posedge clk) disable iff (!resetn)
        (start && !promiscuous && !hashPerfectSelect && inverseFilter
            && !(destAddr[0] && passAllMulticast))
        |=> (filterPass == ($past(destAddr) != $past(stationAddr)));
    endproperty
    a_inverse: assert property (p_inverse)
        else $error("inverse perfect filter wrong");

    property p_hash_only;
        @(posedge clk) disable iff (!resetn)
        (start && !promiscuous && hashPerfectSelect && hashOnlyFilter
            && !destAddr[0]) |=> (filterPass == $past(hashHit));
    endproperty
    a_hash_only: assert property (p_hash_only)
        else $error("hash-only individual address not hashed");

    property p_hash_ia_perfect;
        @(posedge clk) disable iff (!resetn)
        (start && !promiscuous && hashPerfectSelect && !hashOnlyFilter
            && !destAddr[0]) |=> (filterPass == $past(perfectHit));
    endproperty
    a_hash_ia_perfect: assert property (p_hash_ia_perfect)
        else $error("individual address not perfect filtered");

endmodule

//--- core/mac_mode_pkg.sv
// Constants shared by the MAC mode and address filter control block
package mac_mode_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_MODE_CONTROL = 12'h100;
    localparam logic [11:0] ADDR_STATION_HIGH = 12'h104;
    localparam logic [11:0] ADDR_STATION_LOW = 12'h108;
    localparam logic [11:0] ADDR_HASH_HIGH = 12'h10C;
    localparam logic [11:0] ADDR_HASH_LOW = 12'h110;
    localparam logic [11:0] ADDR_MODE_STATUS = 12'h200;

    // ------------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------------
    localparam int BIT_RECEIVE_ALL = 31;
    localparam int BIT_DISABLE_OWN = 23;
    localparam int BIT_LOOPBACK = 21;
    localparam int BIT_FULL_DUPLEX = 20;
    localparam int BIT_PASS_MCAST = 19;
    localparam int BIT_PROMISCUOUS = 18;
    localparam int BIT_INVERSE = 17;
    localparam int BIT_PASS_BAD = 16;
    localparam int BIT_HASH_ONLY = 15;
    localparam int BIT_HASH_PERFECT = 13;
    localparam logic [31:0] CONTROL_WRITABLE = 32'h80BF_A000;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic RST_PROMISCUOUS = 1'b1;
    localparam logic RST_OTHER_MODE = 1'b0;
    localparam logic [47:0] RST_STATION = 48'h0;
    localparam logic [63:0] RST_HASH = 64'h0;

    // ------------------------------------------------------------------
    // Timing and hashing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int LOOPBACK_SETTLE_NS = 10000;
    localparam int LB_SETTLE_CYCLES = LOOPBACK_SETTLE_NS / CLK_PERIOD_NS;
    localparam logic [31:0] CRC_POLY = 32'h04C1_1DB7;
    localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;

endpackage

//--- core/mac_rx_tx_mode_filter_control.sv
// MAC receive/transmit mode control with APB registers and frame filtering
`timescale 1ns/1ps
module mac_rx_tx_mode_filter_control (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic macTxEn,
    input wire logic [3:0] macTxd,
    input wire logic phyRxDv,
    input wire logic [3:0] phyRxd,
    output logic transmitEnableOut,
    output logic [3:0] phyTxd,
    output logic rxPathDv,
    output logic [3:0] rxPathD,
    input wire logic rxFrameStart,
    input wire logic [47:0] rxDestAddr,
    input wire logic rxFrameEnd,
    input wire logic rxFrameBad,
    output logic rxForward,
    output logic rxDiscard,
    output logic rxFilterPass,
    output logic fullDuplexOut,
    output logic loopbackActive
);
    import mac_mode_pkg::*;

    // ------------------------------------------------------------------
    // Software control state
    // ------------------------------------------------------------------
    logic receiveAll_reg;
    logic disableReceiveOwn_reg;
    logic loopbackSelect_reg;
    logic fullDuplex_reg;
    logic passAllMulticast_reg;
    logic promiscuous_reg;
    logic inverseFilter_reg;
    logic passBadFrames_reg;
    logic hashOnlyFilter_reg;
    logic hashPerfectSelect_reg;
    logic [47:0] stationAddr_reg;
    logic [63:0] hashTable_reg;

    // Settings frozen for the frame in flight
    logic appliedReceiveAll_reg;
    logic appliedDisableOwn_reg;
    logic appliedFullDuplex_reg;
    logic appliedPassBad_reg;

    logic loopbackActive_reg;
    logic [9:0] settleCount_reg;
    logic inFrame_reg;
    logic frameSawTx_reg;
    logic filterPass;
    logic loopbackEffective;
    logic sawTx;
    logic forwardDecision;

    logic [31:0] prdata_reg;
    logic [31:0] readMux;
    logic [31:0] controlValue;
    logic [31:0] statusValue;
    logic pslverr_reg;
    logic mapped;
    logic writeAccess;

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    assign mapped = (paddr == ADDR_MODE_CONTROL)
        || (paddr == ADDR_STATION_HIGH) || (paddr == ADDR_STATION_LOW)
        || (paddr == ADDR_HASH_HIGH) || (paddr == ADDR_HASH_LOW)
        || (paddr == ADDR_MODE_STATUS);
    assign writeAccess = psel && penable && pwrite && mapped;
    assign pready = psel && penable;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;

    always_comb begin
        controlValue = 32'h0000_0000;
        controlValue[BIT_RECEIVE_ALL] = receiveAll_reg;
        controlValue[BIT_DISABLE_OWN] = disableReceiveOwn_reg;
        controlValue[BIT_LOOPBACK] = loopbackSelect_reg;
        controlValue[BIT_FULL_DUPLEX] = fullDuplex_reg;
        controlValue[BIT_PASS_MCAST] = passAllMulticast_reg;
        controlValue[BIT_PROMISCUOUS] = promiscuous_reg;
        controlValue[BIT_INVERSE] = inverseFilter_reg;
        controlValue[BIT_PASS_BAD] = passBadFrames_reg;
        controlValue[BIT_HASH_ONLY] = hashOnlyFilter_reg;
        controlValue[BIT_HASH_PERFECT] = hashPerfectSelect_reg;
    end

    assign statusValue = {27'h0, fullDuplexOut, rxFilterPass, inFrame_reg,
        (loopbackSelect_reg != loopbackActive_reg), loopbackActive_reg};

    always_comb begin
        case (paddr)
            ADDR_MODE_CONTROL: begin
                readMux = controlValue;
            end
            ADDR_STATION_HIGH: begin
                readMux = {16'h0000, stationAddr_reg[47:32]};
            end
            ADDR_STATION_LOW: begin
                readMux = stationAddr_reg[31:0];
            end
            ADDR_HASH_HIGH: begin
                readMux = hashTable_reg[63:32];
            end
            ADDR_HASH_LOW: begin
                readMux = hashTable_reg[31:0];
            end
            ADDR_MODE_STATUS: begin
                readMux = statusValue;
            end
            default: begin
                readMux = 32'h0000_0000;
            end
        endcase
    end

    // Read data is captured in the setup cycle so it leaves a flop
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (psel && !penable) begin
            prdata_reg <= pwrite ? 32'h0000_0000 : readMux;
            pslverr_reg <= !mapped;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            receiveAll_reg <= RST_OTHER_MODE;
            disableReceiveOwn_reg <= RST_OTHER_MODE;
            loopbackSelect_reg <= RST_OTHER_MODE;
            fullDuplex_reg <= RST_OTHER_MODE;
            passAllMulticast_reg <= RST_OTHER_MODE;
            promiscuous_reg <= RST_PROMISCUOUS;
            inverseFilter_reg <= RST_OTHER_MODE;
            passBadFrames_reg <= RST_OTHER_MODE;
            hashOnlyFilter_reg <= RST_OTHER_MODE;
            hashPerfectSelect_reg <= RST_OTHER_MODE;
        end else if (writeAccess && paddr == ADDR_MODE_CONTROL) begin
            // Only defined fields are stored; reserved bits are dropped
            receiveAll_reg <= pwdata[BIT_RECEIVE_ALL];
            disableReceiveOwn_reg <= pwdata[BIT_DISABLE_OWN];
            loopbackSelect_reg <= pwdata[BIT_LOOPBACK];
            fullDuplex_reg <= pwdata[BIT_FULL_DUPLEX];
            passAllMulticast_reg <= pwdata[BIT_PASS_MCAST];
            promiscuous_reg <= pwdata[BIT_PROMISCUOUS];
            inverseFilter_reg <= pwdata[BIT_INVERSE];
            passBadFrames_reg <= pwdata[BIT_PASS_BAD];
            hashOnlyFilter_reg <= pwdata[BIT_HASH_ONLY];
            hashPerfectSelect_reg <= pwdata[BIT_HASH_PERFECT];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stationAddr_reg <= RST_STATION;
            hashTable_reg <= RST_HASH;
        end else if (writeAccess) begin
            case (paddr)
                ADDR_STATION_HIGH: begin
                    stationAddr_reg[47:32] <= pwdata[15:0];
                end
                ADDR_STATION_LOW: begin
                    stationAddr_reg[31:0] <= pwdata;
                end
                ADDR_HASH_HIGH: begin
                    hashTable_reg[63:32] <= pwdata;
                end
                ADDR_HASH_LOW: begin
                    hashTable_reg[31:0] <= pwdata;
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Frame-boundary application of settings
    // ------------------------------------------------------------------
    // Loading only between frames keeps a frame from seeing a half-applied
    // mode; the start cycle itself still loads, so the new frame gets it.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            appliedReceiveAll_reg <= RST_OTHER_MODE;
            appliedDisableOwn_reg <= RST_OTHER_MODE;
            appliedFullDuplex_reg <= RST_OTHER_MODE;
            appliedPassBad_reg <= RST_OTHER_MODE;
        end else if (!inFrame_reg) begin
            appliedReceiveAll_reg <= receiveAll_reg;
            appliedDisableOwn_reg <= disableReceiveOwn_reg;
            appliedFullDuplex_reg <= fullDuplex_reg;
            appliedPassBad_reg <= passBadFrames_reg;
        end
    end

    assign fullDuplexOut = appliedFullDuplex_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            inFrame_reg <= 1'b0;
            frameSawTx_reg <= 1'b0;
        end else if (rxFrameStart) begin
            inFrame_reg <= 1'b1;
            frameSawTx_reg <= macTxEn;
        end else if (rxFrameEnd) begin
            inFrame_reg <= 1'b0;
            frameSawTx_reg <= 1'b0;
        end else if (inFrame_reg && macTxEn) begin
            frameSawTx_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Loopback mode change
    // ------------------------------------------------------------------
    // The switch waits LB_SETTLE_CYCLES - 1 clocks, one short of the settle time,
    // before the old path gives way to the new one.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            loopbackActive_reg <= 1'b0;
            settleCount_reg <= 10'h000;
        end else if (loopbackSelect_reg == loopbackActive_reg) begin
            settleCount_reg <= 10'h000;
        end else if (settleCount_reg == 10'(LB_SETTLE_CYCLES - 2)) begin
            loopbackActive_reg <= loopbackSelect_reg;
            settleCount_reg <= 10'h000;
        end else begin
            settleCount_reg <= settleCount_reg + 10'h001;
        end
    end

    assign loopbackActive = loopbackActive_reg;
    // Loopback has no meaning in half duplex
    assign loopbackEffective = loopbackActive_reg && appliedFullDuplex_reg;

    // ------------------------------------------------------------------
    // MII path steering
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            transmitEnableOut <= 1'b0;
            phyTxd <= 4'h0;
            rxPathDv <= 1'b0;
            rxPathD <= 4'h0;
        end else if (loopbackEffective) begin
            transmitEnableOut <= 1'b0;
            phyTxd <= 4'h0;
            rxPathDv <= macTxEn;
            rxPathD <= macTxd;
        end else begin
            transmitEnableOut <= macTxEn;
            phyTxd <= macTxd;
            rxPathDv <= phyRxDv && !(appliedDisableOwn_reg && macTxEn);
            rxPathD <= phyRxd;
        end
    end

    // ------------------------------------------------------------------
    // Address filter and frame decision
    // ------------------------------------------------------------------
    mac_addr_filter filterUnit (
        .clk(clk),
        .resetn(resetn),
        .start(rxFrameStart),
        .destAddr(rxDestAddr),
        .stationAddr(stationAddr_reg),
        .hashTable(hashTable_reg),
        .promiscuous(promiscuous_reg),
        .passAllMulticast(passAllMulticast_reg),
        .inverseFilter(inverseFilter_reg),
        .hashOnlyFilter(hashOnlyFilter_reg),
        .hashPerfectSelect(hashPerfectSelect_reg),
        .filterPass(filterPass)
    );

    assign sawTx = frameSawTx_reg || macTxEn;
    // Receive-all overrides the filter but not own-frame or bad-frame drops
    assign forwardDecision = (filterPass || appliedReceiveAll_reg)
        && (!rxFrameBad || appliedPassBad_reg)
        && !(appliedDisableOwn_reg && sawTx);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rxForward <= 1'b0;
            rxDiscard <= 1'b0;
            rxFilterPass <= 1'b0;
        end else begin
            rxForward <= rxFrameEnd && forwardDecision;
            rxDiscard <= rxFrameEnd && !forwardDecision;
            if (rxFrameEnd) begin
                rxFilterPass <= filterPass;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_receive_all;
        @(posedge clk) disable iff (!resetn)
        (rxFrameEnd && appliedReceiveAll_reg && !appliedDisableOwn_reg
            && !rxFrameBad) |=> (rxForward && !rxDiscard);
    endproperty
    a_receive_all: assert property (p_receive_all)
        else $error("receive-all frame not forwarded");

    property p_own_block;
        @(posedge clk) disable iff (!resetn)
        (rxFrameEnd && appliedDisableOwn_reg && sawTx)
        |=> (rxDiscard && !rxForward);
    endproperty
    a_own_block: assert property (p_own_block)
        else $error("own frame not dropped");

    property p_loopback_path;
        @(posedge clk) disable iff (!resetn)
        (loopbackEffective && macTxEn)
        |=> (rxPathDv && !transmitEnableOut && rxPathD == $past(macTxd));
    endproperty
    a_loopback_path: assert property (p_loopback_path)
        else $error("loopback frame reached the PHY or was lost");

    property p_loopback_settle;
        @(posedge clk) disable iff (!resetn)
        $changed(loopbackSelect_reg)
        |-> ##[1:1000] (loopbackActive_reg == loopbackSelect_reg);
    endproperty
    a_loopback_settle: assert property (p_loopback_settle)
        else $error("loopback change took too long");

    property p_full_duplex;
        @(posedge clk) disable iff (!resetn)
        (!inFrame_reg && !rxFrameStart && fullDuplex_reg) |=> fullDuplexOut;
    endproperty
    a_full_duplex: assert property (p_full_duplex)
        else $error("full duplex not applied between frames");

    property p_prom_reset;
        @(posedge clk) disable iff (!resetn)
        $rose(resetn) |-> controlValue[BIT_PROMISCUOUS];
    endproperty
    a_prom_reset: assert property (p_prom_reset)
        else $error("promiscuous not set after reset");

    property p_bad_drop;
        @(posedge clk) disable iff (!resetn)
        (rxFrameEnd && rxFrameBad && !appliedPassBad_reg) |=> rxDiscard;
    endproperty
    a_bad_drop: assert property (p_bad_drop)
        else $error("bad frame forwarded without pass-bad");

    property p_reserved_zero;
        @(posedge clk) disable iff (!resetn)
        (psel && penable && !pwrite && paddr == ADDR_MODE_CONTROL)
        |-> ((prdata & ~CONTROL_WRITABLE) == 32'h0000_0000);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved control bit read nonzero");

    property p_frame_frozen;
        @(posedge clk) disable iff (!resetn)
        inFrame_reg |=> ($stable(appliedReceiveAll_reg)
            && $stable(appliedPassBad_reg) && $stable(appliedDisableOwn_reg));
    endproperty
    a_frame_frozen: assert property (p_frame_frozen)
        else $error("setting changed inside a frame");

endmodule

//--- verification/mac_rx_tx_mode_filter_control_tb.sv
// Self-checking bench for the MAC mode and filter control block
`timescale 1ns/1ps
module mac_rx_tx_mode_filter_control_tb;
    import mac_mode_pkg::*;
    localparam logic [47:0] STATION = 48'h0000_1234_5670;
    logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rnd = 32'hAE5C31B7;
    logic pready, pslverr, macTxEn = 0, phyRxDv, send = 0;
    logic [3:0] macTxd = 4'h0, phyRxd, sendData = 4'h0, phyTxd, rxPathD;
    logic rxFrameStart = 0, rxFrameEnd = 0, rxFrameBad = 0;
    logic [47:0] rxDestAddr = 48'h0;
    logic transmitEnableOut, rxPathDv, rxForward, rxDiscard;
    logic rxFilterPass, fullDuplexOut, loopbackActive;
    int mismatches = 0, comparisons = 0, n;
    logic [35:0] rq[$], fq[$];
    logic [31:0] ctl [15] = '{32'h0004_0000, 32'h0, 32'h0, 32'h0002_0000,
        32'h0002_2000, 32'h0008_0000, 32'h0008_0000, 32'h8000_0000,
        32'h0, 32'h0001_0000, 32'h0080_0000, 32'h0,
        32'h0000_2000, 32'h0000_2000, 32'h0000_A000};
    // Packed as kind, bad, own tx, forward, filter pass
    logic [5:0] fl [15] = '{6'h13, 6'h03, 6'h10, 6'h13, 6'h20, 6'h23,
        6'h10, 6'h12, 6'h09, 6'h0B, 6'h05, 6'h07, 6'h23, 6'h10, 6'h13};

    mac_rx_tx_mode_filter_control dut_u (.clk, .resetn, .paddr, .psel,
        .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .macTxEn,
        .macTxd, .phyRxDv, .phyRxd, .transmitEnableOut, .phyTxd, .rxPathDv,
        .rxPathD, .rxFrameStart, .rxDestAddr, .rxFrameEnd, .rxFrameBad,
        .rxForward, .rxDiscard, .rxFilterPass, .fullDuplexOut,
        .loopbackActive);
    phy_model phy_u (.clk, .send, .sendData, .rxDv(phyRxDv), .rxd(phyRxd));

    initial begin
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(string nm, logic [35:0] e, logic [35:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ----------------------------------------
    // Bus and frame drivers
    // ----------------------------------------
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
        logic [32:0] e = 33'h0);
        if (!w) rq.push_back({3'h0, e});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            chk("pready", 1, 0);
            give_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge keeps a following setup from reassigning psel at once
        @(posedge clk);
    endtask

    task automatic frame(logic [1:0] k, logic b, logic t, logic f,
        logic p, int len = 3);
        rnd = lfsr(rnd);
        fq.push_back({33'h0, f, !f, p});
        rxFrameStart <= 1'b1;
        rxDestAddr <= k == 0 ? STATION : {rnd[15:0], rnd[31:1], k[1]};
        macTxEn <= t;
        @(posedge clk);
        rxFrameStart <= 1'b0;
        repeat (len) @(posedge clk);
        rxFrameEnd <= 1'b1;
        rxFrameBad <= b;
        @(posedge clk);
        rxFrameEnd <= 1'b0;
        macTxEn <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // Own set gates the receive valid while the MAC transmits
    task automatic mii(logic lb, logic own = 1'b0);
        rnd = lfsr(rnd);
        macTxEn <= 1'b1;
        macTxd <= rnd[3:0];
        send <= 1'b1;
        sendData <= rnd[7:4];
        @(posedge clk);
        #1;
        chk("mii", {!lb, !own, lb ? rnd[3:0] : rnd[7:4], lb ? 4'h0 : rnd[3:0]},
            {transmitEnableOut, rxPathDv, rxPathD, phyTxd});
        @(posedge clk);
        macTxEn <= 1'b0;
        send <= 1'b0;
        @(posedge clk);
    endtask

    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk("read", rq.pop_front(), {3'h0, pslverr, prdata});
        if (rxForward === 1'b1 || rxDiscard === 1'b1)
            chk("frame", fq.size() ? fq.pop_front() : 36'hF,
                {33'h0, rxForward, rxDiscard, rxFilterPass});
    end

    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        apb(0, ADDR_MODE_CONTROL, 0, 33'h0_0004_0000);
        // Every field but full duplex and loopback is set here, so both stay clear
        apb(1, ADDR_MODE_CONTROL, 32'hFFCF_FFFF);
        apb(0, ADDR_MODE_CONTROL, 0,
            {1'b0, CONTROL_WRITABLE & 32'hFFCF_FFFF});
        apb(0, 12'h300, 0, 33'h1_0000_0000);
        apb(1, ADDR_MODE_CONTROL, 32'h0);
        apb(1, ADDR_STATION_HIGH, 32'h0);
        apb(1, ADDR_STATION_LOW, STATION[31:0]);
        mii(0);
        for (int i = 0; i < 15; i++) begin
            if (i == 12) begin
                apb(1, ADDR_HASH_HIGH, 32'hFFFF_FFFF);
                apb(1, ADDR_HASH_LOW, 32'hFFFF_FFFF);
            end
            apb(1, ADDR_MODE_CONTROL, ctl[i]);
            frame(fl[i][5:4], fl[i][3], fl[i][2], fl[i][1],
                fl[i][0]);
            if (i == 10) mii(0, 1);
        end
        apb(1, ADDR_MODE_CONTROL, 32'h0);
        fork
            frame(1, 0, 0, 0, 0, 6);
            begin
                @(posedge clk);
                apb(1, ADDR_MODE_CONTROL, 32'h8000_0000);
            end
        join
        frame(1, 0, 0, 1, 0);
        apb(1, ADDR_MODE_CONTROL, 32'h0010_0000);
        @(posedge clk);
        #1;
        chk("duplex", 1, fullDuplexOut);
        apb(1, ADDR_MODE_CONTROL, 32'h0030_0000);
        n = 0;
        while (loopbackActive !== 1'b1 && n < 1100) begin
            @(posedge clk);
            n++;
        end
        chk("settle", 1, n <= 1000);
        mii(1);
        // Status: loopback in force, none pending, duplex applied
        apb(0, ADDR_MODE_STATUS, 0, 33'h0_0000_0011);
        chk("pending", 0, fq.size());
        give_verdict();
    end

    initial begin
        repeat (40000) @(posedge clk);
        chk("timeout", 0, 1);
        give_verdict();
    end
endmodule

//--- verification/phy_model.sv
// PHY-side model driving the MII receive stream
`timescale 1ns/1ps
module phy_model (
    input wire logic clk,
    input wire logic send,
    input wire logic [3:0] sendData,
    output logic rxDv,
    output logic [3:0] rxd
);
    logic [3:0] lastReg = 4'h0;
    // Idle data toggles, so a stale nibble never looks like a match
    assign rxDv = send;
    assign rxd = send ? sendData : ~lastReg;
    always @(posedge clk) begin
        lastReg <= rxd;
    end
endmodule
